/* File: src/rtcs_pkg.sv */
package rtcs_pkg;

    localparam int CNT_W = 8;
    localparam int SW_N = 7;
    localparam int GRP_N = 3;
    localparam int SEL_W = 3;
    localparam int DIV_W = 3;
    localparam int SYNC_N = 4;

    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_FULL = 8'hFF;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    // Divide-by-six of the capstan reference: counts 0 .. 5
    localparam logic [DIV_W-1:0] DIV_ZERO = 3'h0;
    localparam logic [DIV_W-1:0] DIV_ONE = 3'h1;
    localparam logic [DIV_W-1:0] DIV_LAST = 3'h5;

    // Upper-bit codes at which the mid and large groups take over
    localparam logic [SEL_W-1:0] SEL_MID_FIRST = 3'h3;
    localparam logic [SEL_W-1:0] SEL_LARGE_FIRST = 3'h5;

    // Latched word positions
    localparam int SEL_LSB = CNT_W - SEL_W;
    localparam int SW_LSB = 1;

    // Synchroniser lane assignment
    localparam int LN_CAP = 0;
    localparam int LN_TACH = 1;
    localparam int LN_IDLE = 2;
    localparam int LN_WIDTH = 3;

    localparam int GRP_SMALL = 0;
    localparam int GRP_MID = 1;
    localparam int GRP_LARGE = 2;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HOLD,
        ST_CLEAR
    } rtcs_state_t;

    typedef struct packed {
        logic [GRP_N-1:0] group_en;
        logic [SW_N-1:0] switch_n;
    } rtcs_drive_t;

    typedef struct packed {
        logic drive_one_inch;
        logic drive_two_inch;
    } rtcs_level_t;

endpackage

/* File: src/rtcs_sync.sv */
`timescale 1ns/100ps
module rtcs_sync
    import rtcs_pkg::*;
#(
    parameter logic RST_LEVEL = 1'b0 // Level assumed while in reset
)
(
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic async_in, // Pin level from outside the domain
    output logic level, // Synchronised level
    output logic rise // One-cycle pulse on rising edge
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= RST_LEVEL;
            sync_reg <= RST_LEVEL;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            last_reg <= RST_LEVEL;
        end else begin
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise = sync_reg & ~last_reg;

endmodule

/* File: src/rtcs_top.sv */
`timescale 1ns/100ps
// Overview of operation
// R1 - While window high, count capstan reference divided by six.
// R2 - Window fall stops counting; count stays stable for capture.
// R3 - After window fall, hold strobe copies counter into holding latch.
// R4 - Right after the hold strobe the counter returns to zero.
// R5 - Counter saturates at full value until the clear.
// R6 - Transport idle keeps tension control inactive.
// R7 - Idle presets start-up flip-flop: suppress active, all groups off.
// R8 - Idle clears width register; both drive levels released, full supply.
// R9 - On entering play or record, window low and suppress active.
// R10 - After idle release, first tach pulse raises window, starting a count.
// R11 - First captured count clears suppress in the same step.
// R12 - Without suppress, decode upper bits to exactly one group enable.
// R13 - Seven active-low switch outputs from the latched word.
// R14 - Switch conducts only with group enabled and its bit output low.
// R15 - Width flag sampled on capstan reference divided by two.
// R16 - Width true enables one-inch, complement two-inch, when not idle.
// R17 - No speed setting; count scales with reference frequency.
// R18 - One indicator per group enable, lit while it is high.
// R19 - Group steps small, mid near ten inches, large at fourteen.
// R20 - Counter is eight-bit unsigned pack diameter count.
// R21 - Three latched top bits feed a one-of-eight decoder.
// R22 - Latched LSB dropped; upper seven bits drive switches.
// R23 - Tach pulses halved in toggle flip-flop forming window.
// R24 - Capstan reference, tach inputs synchronised and turned into single-cycle enables.
module rtcs_top
    import rtcs_pkg::*;
(
    input wire logic CLK, // 20 MHz system clock
    input wire logic RST, // Synchronous reset, active high
    input wire logic CAP_REF, // Capstan reference pulse pin
    input wire logic REEL_TACH, // Reel tachometer pulse pin
    input wire logic TRANSPORT_IDLE, // High in stop, rewind, fast-forward
    input wire logic TAPE_WIDTH_FLAG, // High for one-inch tape
    output logic COUNT_WINDOW, // Counting window
    output logic HOLD_STROBE, // One-cycle capture pulse
    output logic [CNT_W-1:0] DIAMETER, // Latched diameter word
    output logic SELECT_SUPPRESS, // Group selection inhibited
    output logic [GRP_N-1:0] ARRAY_GROUP_ENABLE, // One-hot group enables
    output logic [SW_N-1:0] SWITCH_N, // Active-low switch controls
    output logic DRIVE_ONE_INCH, // One-inch drive level enable
    output logic DRIVE_TWO_INCH, // Two-inch drive level enable
    output logic TENSION_ACTIVE, // Control function running
    output logic SMALL_PACK_INDICATOR, // Small group lit
    output logic MID_PACK_INDICATOR, // Mid group lit
    output logic LARGE_PACK_INDICATOR // Large group lit
);

    logic [SYNC_N-1:0] pin_in;
    logic [SYNC_N-1:0] pin_level;
    logic [SYNC_N-1:0] pin_rise;

    logic cap_tick;
    logic tach_tick;
    logic idle;
    logic width_level;

    logic [DIV_W-1:0] div_reg;
    logic half_reg;
    logic count_tick;
    logic half_tick;

    logic window_reg;
    logic window_last_reg;
    logic window_fall;

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] latch_reg;
    logic suppress_reg;
    logic width_reg;

    rtcs_state_t state_reg;
    rtcs_state_t state_next;

    logic [(1<<SEL_W)-1:0] one_of_eight;
    logic [GRP_N-1:0] group_raw;
    rtcs_drive_t drive_next;
    rtcs_level_t level_next;

    assign pin_in[LN_CAP] = CAP_REF;
    assign pin_in[LN_TACH] = REEL_TACH;
    assign pin_in[LN_IDLE] = TRANSPORT_IDLE;
    assign pin_in[LN_WIDTH] = TAPE_WIDTH_FLAG;

    // Every pin passes two flip-flops before use
    generate
        for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
            // Idle lane starts asserted: no false run just after reset
            rtcs_sync #(.RST_LEVEL(i == LN_IDLE)) u_sync (
                .clk(CLK),
                .rst(RST),
                .async_in(pin_in[i]),
                .level(pin_level[i]),
                .rise(pin_rise[i])
            ); // [R24]
        end
    endgenerate

    assign cap_tick = pin_rise[LN_CAP]; // [R24]
    assign tach_tick = pin_rise[LN_TACH]; // [R24]
    assign idle = pin_level[LN_IDLE];
    assign width_level = pin_level[LN_WIDTH];

    // Reference divider: six edges per count tick
    always_ff @(posedge CLK) begin
        if (RST) begin
            div_reg <= DIV_ZERO;
        end else if (cap_tick) begin
            if (div_reg == DIV_LAST) begin
                div_reg <= DIV_ZERO;
            end else begin
                div_reg <= div_reg + DIV_ONE;
            end
        end
    end

    // Rate follows the reference alone, no speed setting [R17]
    assign count_tick = cap_tick && (div_reg == DIV_LAST); // [R1]

    // Half-rate reference for width sampling
    always_ff @(posedge CLK) begin
        if (RST) begin
            half_reg <= 1'b0;
        end else if (cap_tick) begin
            half_reg <= ~half_reg;
        end
    end

    assign half_tick = cap_tick && half_reg; // [R15]

    // Window toggle; held low while idle
    always_ff @(posedge CLK) begin
        if (RST) begin
            window_reg <= 1'b0;
        end else if (idle) begin
            window_reg <= 1'b0; // [R9]
        end else if (tach_tick) begin
            window_reg <= ~window_reg; // [R23] [R10]
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            window_last_reg <= 1'b0;
        end else begin
            window_last_reg <= window_reg;
        end
    end

    assign window_fall = window_last_reg && !window_reg; // [R2]

    // Capture sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (window_fall) begin
                    state_next = ST_HOLD; // [R3]
                end
            end
            ST_HOLD: begin
                state_next = ST_CLEAR; // [R4]
            end
            ST_CLEAR: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_reg <= ST_RUN;
        end else if (idle) begin
            state_reg <= ST_RUN; // [R6]
        end else begin
            state_reg <= state_next;
        end
    end

    // Diameter counter: counts in window, saturates, cleared after hold
    always_ff @(posedge CLK) begin
        if (RST) begin
            cnt_reg <= CNT_ZERO;
        end else if (idle) begin
            cnt_reg <= CNT_ZERO; // [R6]
        end else if (state_reg == ST_CLEAR) begin
            cnt_reg <= CNT_ZERO; // [R4]
        end else if (window_reg && count_tick && state_reg == ST_RUN) begin
            if (cnt_reg != CNT_FULL) begin
                cnt_reg <= cnt_reg + CNT_ONE; // [R1] [R20]
            end // [R5]
        end // [R2]
    end

    // Holding latch
    always_ff @(posedge CLK) begin
        if (RST) begin
            latch_reg <= CNT_ZERO;
        end else if (!idle && state_reg == ST_HOLD) begin
            latch_reg <= cnt_reg; // [R3]
        end
    end

    // Start-up flip-flop: preset by idle, cleared by first capture
    always_ff @(posedge CLK) begin
        if (RST) begin
            suppress_reg <= 1'b1;
        end else if (idle) begin
            suppress_reg <= 1'b1; // [R7] [R9]
        end else if (state_reg == ST_HOLD) begin
            suppress_reg <= 1'b0; // [R11]
        end
    end

    // Width register: cleared by idle, sampled at half rate
    always_ff @(posedge CLK) begin
        if (RST) begin
            width_reg <= 1'b0;
        end else if (idle) begin
            width_reg <= 1'b0; // [R8]
        end else if (half_tick) begin
            width_reg <= width_level; // [R15]
        end
    end

    // One-of-eight decode of the top latched bits
    always_comb begin
        one_of_eight = '0;
        one_of_eight[latch_reg[CNT_W-1:SEL_LSB]] = 1'b1; // [R21]
    end

    // Fold decoder lines into three groups by magnitude
    generate
        for (genvar c = 0; c < (1 << SEL_W); c++) begin : g_fold
            localparam logic [SEL_W-1:0] CODE = SEL_W'(c);
            localparam int GRP = (CODE >= SEL_LARGE_FIRST) ? GRP_LARGE :
                (CODE >= SEL_MID_FIRST) ? GRP_MID : GRP_SMALL;
            logic [GRP_N-1:0] part;
            assign part = one_of_eight[c] ? GRP_N'(1 << GRP) : '0; // [R19]
        end
    endgenerate

    always_comb begin
        group_raw = g_fold[0].part;
        group_raw = group_raw | g_fold[1].part;
        group_raw = group_raw | g_fold[2].part;
        group_raw = group_raw | g_fold[3].part;
        group_raw = group_raw | g_fold[4].part;
        group_raw = group_raw | g_fold[5].part;
        group_raw = group_raw | g_fold[6].part;
        group_raw = group_raw | g_fold[7].part; // [R12]
    end

    always_comb begin
        drive_next.switch_n = ~latch_reg[CNT_W-1:SW_LSB]; // [R13] [R22]
        if (suppress_reg || idle) begin
            drive_next.group_en = '0; // [R7] [R14]
        end else begin
            drive_next.group_en = group_raw; // [R12] [R14]
        end
    end

    always_comb begin
        if (idle) begin
            level_next.drive_one_inch = 1'b0; // [R8]
            level_next.drive_two_inch = 1'b0; // [R8]
        end else begin
            level_next.drive_one_inch = width_reg; // [R16]
            level_next.drive_two_inch = ~width_reg; // [R16]
        end
    end

    // Output registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            ARRAY_GROUP_ENABLE <= '0;
        end else begin
            ARRAY_GROUP_ENABLE <= drive_next.group_en;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            SWITCH_N <= '1;
        end else begin
            SWITCH_N <= drive_next.switch_n;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            SMALL_PACK_INDICATOR <= 1'b0;
            MID_PACK_INDICATOR <= 1'b0;
            LARGE_PACK_INDICATOR <= 1'b0;
        end else begin
            SMALL_PACK_INDICATOR <= drive_next.group_en[GRP_SMALL]; // [R18]
            MID_PACK_INDICATOR <= drive_next.group_en[GRP_MID]; // [R18]
            LARGE_PACK_INDICATOR <= drive_next.group_en[GRP_LARGE]; // [R18]
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            DRIVE_ONE_INCH <= 1'b0;
            DRIVE_TWO_INCH <= 1'b0;
        end else begin
            DRIVE_ONE_INCH <= level_next.drive_one_inch;
            DRIVE_TWO_INCH <= level_next.drive_two_inch;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            COUNT_WINDOW <= 1'b0;
            HOLD_STROBE <= 1'b0;
        end else begin
            COUNT_WINDOW <= window_reg;
            HOLD_STROBE <= !idle && state_reg == ST_HOLD; // [R3]
        end
    end

    // Suppress rises with idle, in step with the groups going off
    always_ff @(posedge CLK) begin
        if (RST) begin
            DIAMETER <= CNT_ZERO;
            SELECT_SUPPRESS <= 1'b1;
        end else begin
            DIAMETER <= latch_reg;
            SELECT_SUPPRESS <= suppress_reg || idle; // [R7]
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            TENSION_ACTIVE <= 1'b0;
        end else begin
            TENSION_ACTIVE <= !idle; // [R6]
        end
    end

endmodule

/* File: sim/rtcs_top_sva.sv */
`timescale 1ns/100ps
module rtcs_top_sva
    import rtcs_pkg::*;
(
    input wire logic CLK, // Clock
    input wire logic RST, // Reset
    input wire logic CAP_REF, // Capstan ref
    input wire logic REEL_TACH, // Reel tach
    input wire logic TRANSPORT_IDLE, // Idle
    input wire logic TAPE_WIDTH_FLAG, // Width
    input wire logic COUNT_WINDOW, // Window
    input wire logic HOLD_STROBE, // Capture
    input wire logic [CNT_W-1:0] DIAMETER, // Latch
    input wire logic SELECT_SUPPRESS, // Inhibit
    input wire logic [GRP_N-1:0] ARRAY_GROUP_ENABLE, // Groups
    input wire logic [SW_N-1:0] SWITCH_N, // Switches
    input wire logic DRIVE_ONE_INCH, // One-inch
    input wire logic DRIVE_TWO_INCH, // Two-inch
    input wire logic TENSION_ACTIVE, // Running
    input wire logic SMALL_PACK_INDICATOR, // Lamp
    input wire logic MID_PACK_INDICATOR, // Lamp
    input wire logic LARGE_PACK_INDICATOR // Lamp
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    function automatic logic [GRP_N-1:0] grp_of(input logic [CNT_W-1:0] d);
        if (d[7:5] < SEL_MID_FIRST) return 3'h1;
        if (d[7:5] < SEL_LARGE_FIRST) return 3'h2;
        return 3'h4;
    endfunction

    chk_group_decode: assert property (
        !SELECT_SUPPRESS && !HOLD_STROBE |-> ARRAY_GROUP_ENABLE == grp_of(DIAMETER))
        else $error("group enable does not match latched word");
    chk_suppress_groups: assert property (
        SELECT_SUPPRESS |-> ARRAY_GROUP_ENABLE == 3'h0)
        else $error("group enabled while suppressed");
    chk_ind_follow: assert property (
        {LARGE_PACK_INDICATOR, MID_PACK_INDICATOR, SMALL_PACK_INDICATOR}
        == ARRAY_GROUP_ENABLE)
        else $error("indicators differ from group enables");
    chk_hold_single: assert property (HOLD_STROBE |=> !HOLD_STROBE)
        else $error("hold strobe longer than one cycle");
    chk_hold_after_fall: assert property (
        $fell(COUNT_WINDOW) && !TRANSPORT_IDLE |-> ##[0:3] HOLD_STROBE)
        else $error("no capture after window fall");
    chk_diam_only_hold: assert property ($changed(DIAMETER) |-> $past(HOLD_STROBE))
        else $error("latched word changed without capture");
    chk_switch_map: assert property (
        !HOLD_STROBE |-> SWITCH_N == ~DIAMETER[7:1])
        else $error("switch outputs do not follow latch");
    chk_drive_idle: assert property (
        !TENSION_ACTIVE |-> !DRIVE_ONE_INCH && !DRIVE_TWO_INCH)
        else $error("drive level enabled while idle");
    chk_drive_excl: assert property (DRIVE_ONE_INCH |-> !DRIVE_TWO_INCH)
        else $error("both drive levels enabled");
    chk_idle_suppress: assert property (
        $fell(TENSION_ACTIVE) |-> ##[0:2] SELECT_SUPPRESS)
        else $error("idle did not suppress selection");
endmodule

bind rtcs_top rtcs_top_sva u_chk (.CLK(CLK), .RST(RST), .CAP_REF(CAP_REF),
    .REEL_TACH(REEL_TACH), .TRANSPORT_IDLE(TRANSPORT_IDLE),
    .TAPE_WIDTH_FLAG(TAPE_WIDTH_FLAG), .COUNT_WINDOW(COUNT_WINDOW),
    .HOLD_STROBE(HOLD_STROBE), .DIAMETER(DIAMETER), .SELECT_SUPPRESS(SELECT_SUPPRESS),
    .ARRAY_GROUP_ENABLE(ARRAY_GROUP_ENABLE), .SWITCH_N(SWITCH_N),
    .DRIVE_ONE_INCH(DRIVE_ONE_INCH), .DRIVE_TWO_INCH(DRIVE_TWO_INCH),
    .TENSION_ACTIVE(TENSION_ACTIVE), .SMALL_PACK_INDICATOR(SMALL_PACK_INDICATOR),
    .MID_PACK_INDICATOR(MID_PACK_INDICATOR), .LARGE_PACK_INDICATOR(LARGE_PACK_INDICATOR));

/* File: sim/rtcs_far_model.sv */
`timescale 1ns/100ps
module rtcs_far_model (
    input wire logic CLK, // System clock
    output logic CAP_REF, // Capstan reference
    output logic REEL_TACH // Reel tach
);
    initial begin
        CAP_REF = 1'b0;
        REEL_TACH = 1'b0;
    end

    // Three cycles high, three low: wide enough for the synchronisers
    task automatic cap_burst(input int n);
        repeat (n) begin
            @(posedge CLK) CAP_REF <= 1'b1;
            repeat (3) @(posedge CLK);
            CAP_REF <= 1'b0;
            repeat (2) @(posedge CLK);
        end
    endtask

    task automatic pulse_tach();
        @(posedge CLK) REEL_TACH <= 1'b1;
        repeat (3) @(posedge CLK);
        REEL_TACH <= 1'b0;
        repeat (3) @(posedge CLK);
    endtask
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import rtcs_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic TRANSPORT_IDLE = 1'b1;
    logic TAPE_WIDTH_FLAG = 1'b0;
    logic cap_ref, reel_tach, count_window, hold_strobe, select_suppress;
    logic drive_one, drive_two, tension_active, ind_small, ind_mid, ind_large;
    logic [CNT_W-1:0] diameter;
    logic [GRP_N-1:0] group_en;
    logic [SW_N-1:0] switch_n;
    logic [CNT_W-1:0] exp_q[$];
    logic [CNT_W-1:0] d;
    logic [31:0] seed = 32'h0000_A162;
    int n_errors = 0;
    int samples_checked = 0;
    int ns[6] = '{1, 95, 96, 160, 0, 300};
    int n;

    always #25 CLK = ~CLK;

    rtcs_far_model u_far (.CLK(CLK), .CAP_REF(cap_ref), .REEL_TACH(reel_tach));

    rtcs_top u_dut (.CLK(CLK), .RST(RST), .CAP_REF(cap_ref), .REEL_TACH(reel_tach),
        .TRANSPORT_IDLE(TRANSPORT_IDLE), .TAPE_WIDTH_FLAG(TAPE_WIDTH_FLAG),
        .COUNT_WINDOW(count_window), .HOLD_STROBE(hold_strobe), .DIAMETER(diameter),
        .SELECT_SUPPRESS(select_suppress), .ARRAY_GROUP_ENABLE(group_en),
        .SWITCH_N(switch_n), .DRIVE_ONE_INCH(drive_one), .DRIVE_TWO_INCH(drive_two),
        .TENSION_ACTIVE(tension_active), .SMALL_PACK_INDICATOR(ind_small),
        .MID_PACK_INDICATOR(ind_mid), .LARGE_PACK_INDICATOR(ind_large));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] grp(input logic [CNT_W-1:0] v);
        if (v[7:5] < SEL_MID_FIRST) return 8'h01;
        if (v[7:5] < SEL_LARGE_FIRST) return 8'h02;
        return 8'h04;
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic wait_win(input logic lvl);
        for (int i = 0; i < 40; i++) begin
            @(posedge CLK);
            if (count_window === lvl) return;
        end
        chk("window", {7'h00, lvl}, {7'h00, count_window});
        wrap_up();
    endtask

    task automatic idle_state();
        chk("suppress", 8'h01, {7'h00, select_suppress});
        chk("groups", 8'h00, {5'h00, group_en});
        chk("drives", 8'h00, {6'h00, drive_one, drive_two});
        chk("tension", 8'h00, {7'h00, tension_active});
    endtask

    // Scoreboard: compares each capture against the oldest note
    initial begin
        forever begin
            @(posedge CLK);
            if (hold_strobe === 1'b1) begin
                @(posedge CLK);
                if (exp_q.size() == 0) chk("capture count", 8'h00, 8'h01);
                else begin
                    d = exp_q.pop_front();
                    chk("diameter", d, diameter);
                    chk("suppress", 8'h00, {7'h00, select_suppress});
                    chk("groups", grp(d), {5'h00, group_en});
                    chk("switches", {1'b1, ~d[7:1]}, {1'b1, switch_n});
                    chk("lamps", grp(d), {5'h00, ind_large, ind_mid, ind_small});
                end
            end
        end
    end

    initial begin
        #5000000;
        chk("run time", 8'h00, 8'h01);
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        repeat (2) @(posedge CLK);
        idle_state();
        TRANSPORT_IDLE <= 1'b0;
        repeat (6) @(posedge CLK);
        chk("tension", 8'h01, {7'h00, tension_active});
        for (int w = 0; w < 2; w++) begin
            @(posedge CLK) TAPE_WIDTH_FLAG <= (w == 0) ? (rnd() % 2 == 1) : !TAPE_WIDTH_FLAG;
            u_far.cap_burst(4);
            repeat (4) @(posedge CLK);
            chk("drive one", {7'h00, TAPE_WIDTH_FLAG}, {7'h00, drive_one});
            chk("drive two", {7'h00, ~TAPE_WIDTH_FLAG}, {7'h00, drive_two});
        end
        chk("window", 8'h00, {7'h00, count_window});
        chk("suppress", 8'h01, {7'h00, select_suppress});
        for (int k = 0; k < 6; k++) begin
            n = (k == 4) ? 1 + int'(rnd() % 255) : ns[k];
            exp_q.push_back((n > 255) ? CNT_FULL : CNT_W'(n));
            u_far.pulse_tach();
            wait_win(1'b1);
            u_far.cap_burst(6 * n);
            u_far.pulse_tach();
            wait_win(1'b0);
        end
        repeat (10) @(posedge CLK);
        chk("pending", 8'h00, 8'(exp_q.size()));
        @(posedge CLK) TRANSPORT_IDLE <= 1'b1;
        repeat (8) @(posedge CLK);
        idle_state();
        wrap_up();
    end
endmodule
